// ===== omsc_top.v
// Module-side sideband control: transmitter shut-down, laser fault and light-lost
// flags, presence line and a two-wire serial identification memory.
// Assumes pins arrive asynchronously and open-drain pins are resolved outside.
`timescale 1ns/1ps
`include "omsc_consts.vh"
module omsc_top #(
  parameter INIT_CYC = `OMSC_T_INIT_MAX_MS * (1000000000 / `OMSC_CLK_PERIOD_PS),
  parameter MEM_AW = 8,
  parameter [6:0] DEV_ADDR = `OMSC_DEV_ADDR_DEF
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire transmitter_off_request_i,
  input wire transmitter_off_request_driven_i,
  input wire laser_fault_cond_i,
  input wire rx_signal_present_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  output reg tx_fault_o,
  output reg tx_fault_oe_o,
  output reg received_light_lost_flag_o,
  output reg received_light_lost_flag_oe_o,
  output reg present_o,
  output reg present_oe_o,
  output reg laser_en_o,
  input wire [`OMSC_ADDR_W-1:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rd_data_o,
  output reg irq_o
);
  // ----------------------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------------------
  localparam [31:0] RESET_CYC_W = (`OMSC_T_RESET_MIN_NS * 1000 + `OMSC_CLK_PERIOD_PS - 1) / `OMSC_CLK_PERIOD_PS;
  localparam [11:0] RESET_CYC = RESET_CYC_W[11:0];
  localparam MEM_DEPTH = 1 << MEM_AW;

  // Serial states.
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_AACK = 3'h2;
  localparam [2:0] S_WR = 3'h3;
  localparam [2:0] S_WACK = 3'h4;
  localparam [2:0] S_RD = 3'h5;
  localparam [2:0] S_RACK = 3'h6;

  // ----------------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------------
  wire off_pin_s;
  wire off_drv_s;
  wire fault_s;
  wire rx_sig_s;
  wire scl_s;
  wire sda_s;

  omsc_sync2 #(.RST_VAL(1'b1)) u_sync_off (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .async_i(transmitter_off_request_i), .sync_o(off_pin_s));
  omsc_sync2 #(.RST_VAL(1'b0)) u_sync_drv (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .async_i(transmitter_off_request_driven_i), .sync_o(off_drv_s));
  omsc_sync2 #(.RST_VAL(1'b0)) u_sync_flt (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .async_i(laser_fault_cond_i), .sync_o(fault_s));
  omsc_sync2 #(.RST_VAL(1'b0)) u_sync_rx (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .async_i(rx_signal_present_i), .sync_o(rx_sig_s));
  omsc_sync2 #(.RST_VAL(1'b1)) u_sync_scl (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .async_i(scl_i), .sync_o(scl_s));
  omsc_sync2 #(.RST_VAL(1'b1)) u_sync_sda (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .async_i(sda_i), .sync_o(sda_s));

  // ----------------------------------------------------------------------------
  // Transmitter control and fault latch
  // ----------------------------------------------------------------------------
  reg [31:0] init_cnt_reg;
  reg init_done_reg;
  reg fault_latch_reg;
  reg [11:0] off_cnt_reg;
  reg soft_off_reg;
  reg off_req_prev_reg;
  reg light_prev_reg;
  reg fault_prev_reg;

  // An input that nobody drives falls back to the internal pull-up level.
  wire off_req = off_pin_s | ~off_drv_s;
  wire light_lost = ~rx_sig_s;

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      init_cnt_reg <= 32'h0;
      init_done_reg <= 1'b0;
      fault_latch_reg <= 1'b0;
      off_cnt_reg <= 12'h0;
      laser_en_o <= 1'b0;
      tx_fault_o <= 1'b0;
      tx_fault_oe_o <= 1'b0;
      received_light_lost_flag_o <= 1'b0;
      received_light_lost_flag_oe_o <= 1'b0;
      present_o <= 1'b0;
      present_oe_o <= 1'b1;
    end else begin
      // Laser stays dark until the start-up count expires.
      if (!init_done_reg) begin
        if (init_cnt_reg >= INIT_CYC - 1)
          init_done_reg <= 1'b1;
        init_cnt_reg <= init_cnt_reg + 32'h1;
      end
      // A fault is latched; only an off request held for the reset time clears it.
      if (off_req && off_cnt_reg < RESET_CYC)
        off_cnt_reg <= off_cnt_reg + 12'h1;
      else if (!off_req)
        off_cnt_reg <= 12'h0;
      if (init_done_reg && fault_s)
        fault_latch_reg <= 1'b1;
      else if (off_cnt_reg >= RESET_CYC)
        fault_latch_reg <= 1'b0;
      // Shut-down acts in the cycle after the synchronised request, far inside the limit.
      // The raw fault also gates, so a fault standing at the end of start-up never shows a clear cycle.
      laser_en_o <= init_done_reg & ~off_req & ~soft_off_reg & ~fault_latch_reg & ~fault_s;
      // Open-drain: releasing the pin lets the host pull-up show a high flag.
      tx_fault_o <= 1'b0;
      tx_fault_oe_o <= init_done_reg & ~fault_latch_reg & ~fault_s;
      received_light_lost_flag_o <= 1'b0;
      received_light_lost_flag_oe_o <= ~light_lost;
      present_o <= 1'b0;
      present_oe_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Two-wire serial identification slave
  // ----------------------------------------------------------------------------
  reg [7:0] id_mem_reg [0:MEM_DEPTH-1];
  reg [MEM_AW-1:0] mem_ptr_reg;
  reg [MEM_AW-1:0] sw_ptr_reg;
  reg [2:0] st_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] rx_sh_reg;
  reg [7:0] tx_sh_reg;
  reg rw_reg;
  reg first_reg;
  reg master_ack_reg;
  reg scl_d_reg;
  reg sda_d_reg;
  reg serial_hit_reg;

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [7:0] mem_byte = id_mem_reg[mem_ptr_reg];

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_reg <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      mem_ptr_reg <= {MEM_AW{1'b0}};
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      serial_hit_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      sda_o <= 1'b0;
      serial_hit_reg <= 1'b0;
      if (start_cond) begin
        st_reg <= S_ADDR;
        bit_cnt_reg <= 4'h0;
        first_reg <= 1'b1;
        sda_oe_o <= 1'b0;
      end else if (stop_cond) begin
        st_reg <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if (st_reg == S_ADDR || st_reg == S_WR) begin
          rx_sh_reg <= {rx_sh_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (st_reg == S_RACK) begin
          master_ack_reg <= ~sda_s;
        end
      end else if (scl_fall) begin
        case (st_reg)
          S_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (rx_sh_reg[7:1] == DEV_ADDR) begin
                st_reg <= S_AACK;
                rw_reg <= rx_sh_reg[0];
                sda_oe_o <= 1'b1;
                serial_hit_reg <= 1'b1;
              end else begin
                st_reg <= S_IDLE;
              end
            end
          end
          S_AACK, S_RACK: begin
            if (st_reg == S_RACK && !master_ack_reg) begin
              st_reg <= S_IDLE;
              sda_oe_o <= 1'b0;
            end else if (rw_reg) begin
              st_reg <= S_RD;
              tx_sh_reg <= mem_byte;
              sda_oe_o <= ~mem_byte[7];
              bit_cnt_reg <= 4'h1;
            end else begin
              st_reg <= S_WR;
              sda_oe_o <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
          S_WR: begin
            if (bit_cnt_reg == 4'h8) begin
              st_reg <= S_WACK;
              sda_oe_o <= 1'b1;
              // The host may only move the pointer; data bytes are acknowledged and dropped.
              if (first_reg)
                mem_ptr_reg <= rx_sh_reg[MEM_AW-1:0];
              first_reg <= 1'b0;
            end
          end
          S_WACK: begin
            st_reg <= S_WR;
            sda_oe_o <= 1'b0;
            bit_cnt_reg <= 4'h0;
          end
          S_RD: begin
            if (bit_cnt_reg == 4'h8) begin
              st_reg <= S_RACK;
              sda_oe_o <= 1'b0;
              mem_ptr_reg <= mem_ptr_reg + {{(MEM_AW-1){1'b0}}, 1'b1};
            end else begin
              sda_oe_o <= ~tx_sh_reg[6];
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          default: begin
            st_reg <= S_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Register port and interrupts
  // ----------------------------------------------------------------------------
  reg [`OMSC_IRQ_W-1:0] irq_stat_reg;
  reg [`OMSC_IRQ_W-1:0] irq_en_reg;
  reg [`OMSC_IRQ_W-1:0] irq_stat_next;
  reg [`OMSC_IRQ_W-1:0] irq_set;
  reg [`OMSC_IRQ_W-1:0] irq_clr;
  reg [31:0] rd_data_next;
  wire [4:0] status_word = {init_done_reg, off_req, light_lost, ~tx_fault_oe_o, laser_en_o};

  always @* begin
    irq_set = {`OMSC_IRQ_W{1'b0}};
    irq_set[`OMSC_IRQ_FAULT] = fault_latch_reg & ~fault_prev_reg;
    irq_set[`OMSC_IRQ_LIGHT] = light_lost ^ light_prev_reg;
    irq_set[`OMSC_IRQ_OFF_REQ] = off_req ^ off_req_prev_reg;
    irq_set[`OMSC_IRQ_SERIAL] = serial_hit_reg;
    irq_clr = (wr_i && addr_i == `OMSC_OFF_IRQ_CLR) ? wr_data_i[`OMSC_IRQ_W-1:0] : {`OMSC_IRQ_W{1'b0}};
    // A new event in the clearing cycle survives the clear.
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    case (addr_i)
      `OMSC_OFF_CTRL: rd_data_next = {{(32-`OMSC_CTRL_W){1'b0}}, soft_off_reg};
      `OMSC_OFF_STATUS: rd_data_next = {27'h0, status_word};
      `OMSC_OFF_IRQ_STAT: rd_data_next = {{(32-`OMSC_IRQ_W){1'b0}}, irq_stat_reg};
      `OMSC_OFF_IRQ_EN: rd_data_next = {{(32-`OMSC_IRQ_W){1'b0}}, irq_en_reg};
      `OMSC_OFF_MEM_PTR: rd_data_next = {{(32-MEM_AW){1'b0}}, sw_ptr_reg};
      `OMSC_OFF_MEM_DATA: rd_data_next = {24'h0, id_mem_reg[sw_ptr_reg]};
      default: rd_data_next = 32'h0;
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      soft_off_reg <= `OMSC_CTRL_RST;
      irq_en_reg <= `OMSC_IRQ_EN_RST;
      irq_stat_reg <= {`OMSC_IRQ_W{1'b0}};
      sw_ptr_reg <= {MEM_AW{1'b0}};
      off_req_prev_reg <= 1'b1;
      light_prev_reg <= 1'b1;
      fault_prev_reg <= 1'b0;
      rd_data_o <= 32'h0;
      irq_o <= 1'b0;
    end else begin
      off_req_prev_reg <= off_req;
      light_prev_reg <= light_lost;
      fault_prev_reg <= fault_latch_reg;
      irq_stat_reg <= irq_stat_next;
      irq_o <= |(irq_stat_next & irq_en_reg);
      rd_data_o <= rd_i ? rd_data_next : 32'h0;
      if (wr_i) begin
        case (addr_i)
          `OMSC_OFF_CTRL: soft_off_reg <= wr_data_i[`OMSC_CTRL_SOFT_OFF];
          `OMSC_OFF_IRQ_EN: irq_en_reg <= wr_data_i[`OMSC_IRQ_W-1:0];
          `OMSC_OFF_MEM_PTR: sw_ptr_reg <= wr_data_i[MEM_AW-1:0];
          `OMSC_OFF_MEM_DATA: sw_ptr_reg <= sw_ptr_reg + {{(MEM_AW-1){1'b0}}, 1'b1};
          default: soft_off_reg <= soft_off_reg;
        endcase
      end
    end
  end

  // Identification memory has no reset; software fills it after start-up.
  always @(posedge mclk_i) begin
    if (wr_i && addr_i == `OMSC_OFF_MEM_DATA)
      id_mem_reg[sw_ptr_reg] <= wr_data_i[7:0];
  end
endmodule // omsc_top

// ===== omsc_consts.vh
// Constants of the optical module sideband controller: timing, register map, fields and resets.
// Assumes a single 250 MHz clock; all times are converted to cycles where they are used.
`ifndef OMSC_CONSTS_VH
`define OMSC_CONSTS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OMSC_CLK_PERIOD_PS 4000
`define OMSC_T_OFF_MAX_NS 10000
`define OMSC_T_ON_MAX_NS 1000000
`define OMSC_T_FAULT_MAX_NS 100000
`define OMSC_T_RESET_MIN_NS 10000
`define OMSC_T_INIT_MAX_MS 300

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OMSC_ADDR_W 8
`define OMSC_OFF_CTRL 8'h00
`define OMSC_OFF_STATUS 8'h04
`define OMSC_OFF_IRQ_STAT 8'h08
`define OMSC_OFF_IRQ_CLR 8'h0C
`define OMSC_OFF_IRQ_EN 8'h10
`define OMSC_OFF_MEM_PTR 8'h14
`define OMSC_OFF_MEM_DATA 8'h18

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define OMSC_CTRL_SOFT_OFF 0
`define OMSC_CTRL_W 1
`define OMSC_ST_LASER_ON 0
`define OMSC_ST_FAULT 1
`define OMSC_ST_LIGHT_LOST 2
`define OMSC_ST_OFF_REQ 3
`define OMSC_ST_INIT_DONE 4
`define OMSC_IRQ_FAULT 0
`define OMSC_IRQ_LIGHT 1
`define OMSC_IRQ_OFF_REQ 2
`define OMSC_IRQ_SERIAL 3
`define OMSC_IRQ_W 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OMSC_CTRL_RST 1'h0
`define OMSC_IRQ_EN_RST 4'h0
`define OMSC_DEV_ADDR_DEF 7'h50

`endif

// ===== omsc_sync2.v
// Two-flop synchroniser for one asynchronous level.
// Assumes the input changes slowly compared with the clock.
`timescale 1ns/1ps
module omsc_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire async_i,
  output reg sync_o
);
  reg meta_reg;

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // omsc_sync2

// ===== omsc_top_assertions.sv
// Concurrent checks on the sideband pins of omsc_top.
// Assumes it is bound to omsc_top and sees only that module's ports.
`timescale 1ns/1ps
module omsc_top_chk (
  input logic mclk_i,
  input logic rst_b_i,
  input logic transmitter_off_request_i,
  input logic transmitter_off_request_driven_i,
  input logic laser_fault_cond_i,
  input logic rx_signal_present_i,
  input logic scl_i,
  input logic sda_o,
  input logic sda_oe_o,
  input logic tx_fault_oe_o,
  input logic received_light_lost_flag_oe_o,
  input logic present_o,
  input logic present_oe_o,
  input logic laser_en_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------------------
  // Six to eight cycles cover the two-flop synchroniser plus decode and output.
  sequence s_off_held;
    (transmitter_off_request_i && transmitter_off_request_driven_i)[*6];
  endsequence
  sequence s_light_held;
    rx_signal_present_i[*8];
  endsequence
  sequence s_dark_held;
    (!rx_signal_present_i)[*8];
  endsequence

  a_off_fast: assert property ($rose(transmitter_off_request_i) |-> ##[1:6] !laser_en_o)
    else $error("laser still on after off request");
  a_off_holds: assert property (s_off_held |-> !laser_en_o)
    else $error("laser on while off request stands");
  a_undriven_off: assert property ((!transmitter_off_request_driven_i)[*6] |-> !laser_en_o)
    else $error("laser on while off pin undriven");
  a_present_grounded: assert property (present_oe_o && !present_o)
    else $error("presence line not grounded");
  a_light_normal: assert property (s_light_held |-> received_light_lost_flag_oe_o)
    else $error("light lost flag high with light present");
  a_light_lost: assert property (s_dark_held |-> !received_light_lost_flag_oe_o)
    else $error("light lost flag low without light");
  a_sda_drives_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_sda_change_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
  a_fault_fast: assert property ($rose(laser_fault_cond_i) |-> ##[1:8] !tx_fault_oe_o)
    else $error("fault flag late");
  a_fault_holds: assert property (laser_fault_cond_i[*8] |-> !tx_fault_oe_o)
    else $error("fault flag low during fault");
endmodule // omsc_top_chk

bind omsc_top omsc_top_chk u_chk (
  .mclk_i,
  .rst_b_i,
  .transmitter_off_request_i,
  .transmitter_off_request_driven_i,
  .laser_fault_cond_i,
  .rx_signal_present_i,
  .scl_i,
  .sda_o,
  .sda_oe_o,
  .tx_fault_oe_o,
  .received_light_lost_flag_oe_o,
  .present_o,
  .present_oe_o,
  .laser_en_o
);

// ===== omsc_host_model.sv
// Host side of the two-wire identification bus.
// Assumes the module pulls the data line low through its enable; the line has a pull-up.
`timescale 1ns/1ps
module omsc_host_model (
  input logic mclk_i,
  input logic sda_oe_i,
  output logic scl_o,
  output logic sda_line_o
);
  logic host_sda;

  // ----------------------------------------------------------------------------
  // Bus driving
  // ----------------------------------------------------------------------------
  assign sda_line_o = host_sda & !sda_oe_i;
  initial begin
    scl_o = 1'b1;
    host_sda = 1'b1;
  end

  // Data moves three cycles after the clock, so it never changes with a clock edge.
  task automatic step(input logic c, input logic d);
    @(posedge mclk_i);
    scl_o <= c;
    repeat (3) @(posedge mclk_i);
    host_sda <= d;
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic probe(input logic [6:0] a, output logic ack);
    logic [7:0] b;
    b = {a, 1'b0};
    step(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, b[i]);
      step(1'b1, b[i]);
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    #1;
    ack = !sda_line_o;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  // Reads one byte at the module's pointer and ends it with a not-acknowledge.
  task automatic fetch(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] b;
    b = {a, 1'b1};
    step(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, b[i]);
      step(1'b1, b[i]);
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      #1;
      d[i] = sda_line_o;
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
endmodule // omsc_host_model

// ===== testbench.sv
// Self-checking bench for omsc_top: pins, register port, interrupt and two-wire bus.
// Assumes a shortened initialisation count so the run stays short.
`timescale 1ns/1ps
module testbench;
  localparam int INIT = 50;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic off_req = 1'b0;
  logic off_drv = 1'b1;
  logic fault = 1'b0;
  logic rx_ok = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic scl, sda, sda_oe, tx_fault_oe, lost_oe, present, present_oe, laser_en, irq, ack;
  logic sda_out, tx_fault, lost;
  logic [7:0] rbyte;
  int n_errors = 0;
  int checks = 0;

  // ----------------------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------------------
  always #2 mclk_i = ~mclk_i;

  omsc_top #(.INIT_CYC(INIT)) dut (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .transmitter_off_request_i(off_req),
    .transmitter_off_request_driven_i(off_drv),
    .laser_fault_cond_i(fault),
    .rx_signal_present_i(rx_ok),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_out),
    .sda_oe_o(sda_oe),
    .tx_fault_o(tx_fault),
    .tx_fault_oe_o(tx_fault_oe),
    .received_light_lost_flag_o(lost),
    .received_light_lost_flag_oe_o(lost_oe),
    .present_o(present),
    .present_oe_o(present_oe),
    .laser_en_o(laser_en),
    .addr_i(addr),
    .wr_data_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rd_data_o(rdata),
    .irq_o(irq)
  );

  omsc_host_model host (.mclk_i(mclk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_line_o(sda));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd_chk(8'h04, 32'h13, 32'h02);
    chk(32'(tx_fault_oe), 32'h0);
    rd_chk(8'h10, 32'hF, 32'h0);
    chk(32'({present_oe, present}), 32'h2);
    chk(32'({sda_out, tx_fault, lost}), 32'h0);
    wt(INIT + 10);
    rd_chk(8'h04, 32'h1F, 32'h11);
    chk(32'({laser_en, tx_fault_oe, lost_oe}), 32'h7);
    $display("test reset done");
    wr_reg(8'h0C, 32'hF);
    wr_reg(8'h10, 32'hF);
    off_req <= 1'b1;
    wt(6);
    chk(32'(laser_en), 32'h0);
    rd_chk(8'h04, 32'h9, 32'h8);
    chk(32'(irq), 32'h1);
    off_req <= 1'b0;
    wt(6);
    chk(32'(laser_en), 32'h1);
    off_drv <= 1'b0;
    wt(6);
    chk(32'(laser_en), 32'h0);
    off_drv <= 1'b1;
    wr_reg(8'h00, 32'h1);
    wt(6);
    chk(32'(laser_en), 32'h0);
    wr_reg(8'h00, 32'h0);
    wt(6);
    chk(32'(laser_en), 32'h1);
    rd_chk(8'h08, 32'h4, 32'h4);
    wr_reg(8'h0C, 32'hF);
    wt(2);
    chk(32'(irq), 32'h0);
    $display("test off request done");
    wr_reg(8'h10, 32'h1);
    rx_ok <= 1'b0;
    wt(8);
    chk(32'({lost_oe, irq}), 32'h0);
    rd_chk(8'h08, 32'h2, 32'h2);
    wr_reg(8'h10, 32'h2);
    wt(2);
    chk(32'(irq), 32'h1);
    rx_ok <= 1'b1;
    wt(8);
    chk(32'(lost_oe), 32'h1);
    wr_reg(8'h0C, 32'h2);
    wt(2);
    chk(32'(irq), 32'h0);
    $display("test light done");
    wr_reg(8'h10, 32'h1);
    fault <= 1'b1;
    wt(8);
    chk(32'({tx_fault_oe, laser_en, irq}), 32'h1);
    rd_chk(8'h04, 32'h3, 32'h2);
    fault <= 1'b0;
    off_req <= 1'b1;
    wt(2600);
    off_req <= 1'b0;
    wt(8);
    chk(32'({tx_fault_oe, laser_en}), 32'h3);
    $display("test fault done");
    rd_chk(8'h1C, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
    wr_reg(8'h14, 32'h3);
    wr_reg(8'h18, 32'hA5);
    wr_reg(8'h14, 32'h3);
    rd_chk(8'h18, 32'hFF, 32'hA5);
    wt(1);
    chk(rdata, 32'h0);
    $display("test registers done");
    wr_reg(8'h0C, 32'hF);
    wr_reg(8'h10, 32'h8);
    host.probe(7'h51, ack);
    chk(32'(ack), 32'h0);
    host.probe(7'h50, ack);
    chk(32'(ack), 32'h1);
    chk(32'(irq), 32'h1);
    wr_reg(8'h14, 32'h0);
    wr_reg(8'h18, 32'h3C);
    host.fetch(7'h50, rbyte);
    chk(32'(rbyte), 32'h3C);
    $display("test serial done");
    fault <= 1'b1;
    rst_b_i <= 1'b0;
    wt(5);
    rst_b_i <= 1'b1;
    wt(INIT + 10);
    chk(32'({tx_fault_oe, laser_en}), 32'h0);
    rd_chk(8'h04, 32'h13, 32'h12);
    $display("test fault at start-up done");
    conclude();
  end

  // The tests need about 4000 cycles; ten times that marks a hang.
  initial begin
    #160000;
    n_errors++;
    conclude();
  end
endmodule // testbench
